/* common/sbfw_pkg.sv */
package sbfw_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] CTRL_ADDR = 8'h27;
    localparam int FLUSH_BIT = 7;
    localparam int KEEP_BIT = 6;
    localparam int THR_MSB = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] THR_RESET = 6'h00;

    // ==========================================================
    // buffer geometry and mode encodings
    localparam logic [5:0] BUF_DEPTH = 6'h20;
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_STREAM = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_TRIGGERED = 2'h3;
    localparam logic [4:0] GATE_CNT_RESET = 5'h00;
    localparam logic [7:0] ASLP_RESET = 8'h00;

    typedef enum logic [1:0] {
        TRIG_ARMED,
        TRIG_CAPTURE,
        TRIG_DONE
    } sbfw_trig_e;

    // buffer status seen by the rest of the device
    typedef struct packed {
        logic overflow_flag;
        logic watermark_flag;
        logic [5:0] sample_count;
    } sbfw_status_s;

    // gate fields of system_state_reg
    typedef struct packed {
        logic gate_err;
        logic [4:0] gate_cnt;
    } sbfw_gate_s;
endpackage

/* src/sbfw_ctrl.sv */
`timescale 1ns/1ns
module sbfw_ctrl
    import sbfw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] buf_mode,
    input wire logic sample_wr,
    input wire logic sample_rd,
    input wire logic trigger_evt,
    input wire logic gate_err_set,
    input wire logic gate_cnt_inc,
    input wire logic [7:0] autosleep_period,
    input wire logic odr_tick,
    input wire logic wake_evt,
    output sbfw_status_s status,
    output sbfw_gate_s gate,
    output logic sleep_mode
);
    // ==========================================================
    // control register
    logic keep_awake_q;
    logic [5:0] thr_q;
    logic flush_q;
    logic ctrl_hit;
    assign ctrl_hit = reg_wr && (reg_addr == CTRL_ADDR);
    // settings store; flush is a one-cycle pulse, never stored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_awake_q <= CTRL_RESET[KEEP_BIT];
            thr_q <= THR_RESET;
            flush_q <= CTRL_RESET[FLUSH_BIT];
        end else begin
            flush_q <= ctrl_hit && reg_wdata[FLUSH_BIT];
            if (ctrl_hit) begin
                keep_awake_q <= reg_wdata[KEEP_BIT];
                thr_q <= reg_wdata[THR_MSB:0];
            end
        end
    end
    // readback; bit 7 is hard zero so the pulse is never seen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= CTRL_RESET;
        end else if (reg_rd && reg_addr == CTRL_ADDR) begin
            reg_rdata <= {1'b0, keep_awake_q, thr_q};
        end else begin
            reg_rdata <= CTRL_RESET;
        end
    end

    // ==========================================================
    // sample count and trigger sequencing
    logic flush_all;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic ovf_q;
    logic wmrk_q;
    logic ovf_evt;
    logic accept;
    logic drop_old;
    logic take_rd;
    sbfw_trig_e trig_q;
    // disabling the buffer is treated exactly like a flush
    assign flush_all = flush_q || (buf_mode == MODE_DISABLED);
    assign take_rd = sample_rd && (cnt_q != 6'h00);
    // decide whether an incoming sample is stored and what it evicts
    always_comb begin
        accept = 1'b0;
        drop_old = 1'b0;
        ovf_evt = 1'b0;
        case (buf_mode)
            MODE_STREAM: begin
                accept = sample_wr;
                drop_old = sample_wr && cnt_q == BUF_DEPTH && !take_rd;
                ovf_evt = drop_old;
            end
            MODE_STOP: begin
                accept = sample_wr && cnt_q != BUF_DEPTH;
                ovf_evt = sample_wr && cnt_q == BUF_DEPTH;
            end
            MODE_TRIGGERED: begin
                if (trig_q == TRIG_ARMED) begin
                    // pre-trigger window slides at threshold depth
                    accept = sample_wr && thr_q != 6'h00;
                    drop_old = accept && cnt_q >= thr_q && !take_rd;
                end else if (trig_q == TRIG_CAPTURE) begin
                    accept = sample_wr && cnt_q != BUF_DEPTH;
                    ovf_evt = accept && cnt_q == BUF_DEPTH - 6'h01
                        && !take_rd;
                end
            end
            default: begin
                accept = 1'b0;
            end
        endcase
    end
    // next count; flush dominates any concurrent sample traffic
    always_comb begin
        cnt_d = cnt_q;
        if (flush_all) begin
            cnt_d = 6'h00;
        end else if (accept && !drop_old && !take_rd) begin
            cnt_d = cnt_q + 6'h01;
        end else if (take_rd && !(accept && !drop_old)) begin
            cnt_d = cnt_q - 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // trigger state: armed, collecting until the buffer holds 32, frozen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q <= TRIG_ARMED;
        end else if (buf_mode != MODE_TRIGGERED || flush_all) begin
            trig_q <= TRIG_ARMED;
        end else begin
            case (trig_q)
                TRIG_ARMED: begin
                    if (trigger_evt) begin
                        trig_q <= TRIG_CAPTURE;
                    end
                end
                TRIG_CAPTURE: begin
                    if (ovf_evt) begin
                        trig_q <= TRIG_DONE;
                    end
                end
                TRIG_DONE: begin
                    // re-armed once the host drains it completely
                    if (cnt_d == 6'h00) begin
                        trig_q <= TRIG_ARMED;
                    end
                end
                default: begin
                    trig_q <= TRIG_ARMED;
                end
            endcase
        end
    end
    // overflow: set beats a clear by reading in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else if (flush_all) begin
            ovf_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_q <= 1'b1;
        end else if (take_rd) begin
            ovf_q <= 1'b0;
        end
    end
    // watermark follows next count, so every count change re-evaluates
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wmrk_q <= 1'b0;
        end else begin
            wmrk_q <= (thr_q != 6'h00)
                && (cnt_d >= thr_q);
        end
    end

    assign status = '{overflow_flag: ovf_q, watermark_flag: wmrk_q,
        sample_count: cnt_q};

    // ==========================================================
    // gate fields of system_state_reg
    logic gate_clr;
    assign gate_clr = flush_all || (take_rd && cnt_d == 6'h00);
    // a gate error landing on the clear cycle still shows
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate <= '{gate_err: 1'b0, gate_cnt: GATE_CNT_RESET};
        end else begin
            if (gate_err_set) begin
                gate.gate_err <= 1'b1;
            end else if (gate_clr) begin
                gate.gate_err <= 1'b0;
            end
            if (gate_clr) begin
                gate.gate_cnt <= GATE_CNT_RESET;
            end else if (gate_cnt_inc) begin
                gate.gate_cnt <= gate.gate_cnt + 5'h01;
            end
        end
    end

    // ==========================================================
    // auto wake/sleep timer
    logic gate_en;
    logic flags_or;
    logic flags_prev_q;
    logic buf_rise;
    logic buf_clear;
    logic [7:0] aslp_q;
    // keep-awake only counts in stream or stop mode
    assign gate_en = keep_awake_q
        && (buf_mode == MODE_STREAM || buf_mode == MODE_STOP);
    assign flags_or = ovf_q || wmrk_q;
    assign buf_rise = gate_en && flags_or && !flags_prev_q;
    // host action that dropped the flags restarts the timer
    assign buf_clear = gate_en && flags_prev_q && !flags_or;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_prev_q <= 1'b0;
        end else begin
            flags_prev_q <= flags_or;
        end
    end
    // a flag merely held high does not refresh the timer, so
    // a host that never services it still lets the part sleep
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aslp_q <= ASLP_RESET;
            sleep_mode <= 1'b0;
        end else if (wake_evt || buf_rise || buf_clear) begin
            aslp_q <= ASLP_RESET;
            sleep_mode <= 1'b0;
        end else if (odr_tick && !sleep_mode
                     && autosleep_period != ASLP_RESET) begin
            if (aslp_q + 8'h01 >= autosleep_period) begin
                aslp_q <= ASLP_RESET;
                sleep_mode <= 1'b1;
            end else begin
                aslp_q <= aslp_q + 8'h01;
            end
        end
    end

    // ==========================================================
    // checks
    a_flush_empties: assert property (@(posedge core_clk)
        disable iff (!rst_n) flush_all |=> cnt_q == 6'h00 && !ovf_q)
        else $error("flush left samples or overflow");
    a_flush_gate: assert property (@(posedge core_clk)
        disable iff (!rst_n) flush_all && !gate_err_set
        |=> !gate.gate_err && gate.gate_cnt == 5'h00)
        else $error("flush left gate fields set");
    a_flush_selfclr: assert property (@(posedge core_clk)
        disable iff (!rst_n) flush_q |=> !flush_q || $past(ctrl_hit))
        else $error("flush bit did not self clear");
    a_read_zero: assert property (@(posedge core_clk)
        disable iff (!rst_n) 1'b1 |-> !reg_rdata[FLUSH_BIT])
        else $error("flush bit read back as one");
    a_wmrk_level: assert property (@(posedge core_clk)
        disable iff (!rst_n) $changed(cnt_q) && $stable(thr_q)
        |-> wmrk_q == (thr_q != 6'h00 && cnt_q >= thr_q))
        else $error("watermark flag wrong after count change");
    a_wmrk_zero: assert property (@(posedge core_clk)
        disable iff (!rst_n) thr_q == 6'h00 ##1 thr_q == 6'h00 |-> !wmrk_q)
        else $error("watermark raised with zero threshold");
    a_mode_ignore: assert property (@(posedge core_clk)
        disable iff (!rst_n) !gate_en && !wake_evt && odr_tick
        && !sleep_mode && autosleep_period != 8'h00
        && aslp_q + 8'h01 < autosleep_period
        |=> aslp_q == $past(aslp_q) + 8'h01)
        else $error("buffer flags touched timer while ignored");
    a_clear_wakes: assert property (@(posedge core_clk)
        disable iff (!rst_n) buf_clear |=> aslp_q == 8'h00 && !sleep_mode)
        else $error("flag clear did not restart timer");
    a_pre_cap: assert property (@(posedge core_clk)
        disable iff (!rst_n) buf_mode == MODE_TRIGGERED
        && trig_q == TRIG_ARMED && cnt_q <= thr_q && $stable(thr_q)
        |=> cnt_q <= $past(thr_q))
        else $error("pre-trigger store exceeded threshold");
    a_trig_stop: assert property (@(posedge core_clk)
        disable iff (!rst_n) buf_mode == MODE_TRIGGERED
        && trig_q == TRIG_DONE && !flush_all
        |-> !accept ##1 (ovf_q || !$past(ovf_q) || $past(take_rd)))
        else $error("collection continued after trigger fill");
endmodule

/* dv/sbfw_sample_src.sv */
`timescale 1ns/1ns
// ==========================================================
// sample source: one odr tick every second cycle, with or
// without a new sample, for a burst of n ticks
module sbfw_sample_src (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [6:0] n,
    input wire logic wr_en,
    output logic sample_wr,
    output logic odr_tick,
    output logic busy
);
    logic [6:0] left_q = 7'h00;
    logic ph_q = 1'b0;
    initial begin
        sample_wr = 1'b0;
        odr_tick = 1'b0;
        busy = 1'b0;
    end
    // outputs move on the edge by nba, so the design sees them one
    // cycle later without any race against its own sampling
    always @(posedge core_clk) begin
        sample_wr <= 1'b0;
        odr_tick <= 1'b0;
        if (go) begin
            left_q <= n;
            busy <= (n != 7'h00);
            ph_q <= 1'b0;
        end else if (left_q != 7'h00) begin
            ph_q <= !ph_q;
            if (ph_q) begin
                odr_tick <= 1'b1;
                sample_wr <= wr_en;
                left_q <= left_q - 7'h01;
                busy <= (left_q != 7'h01);
            end
        end
    end
endmodule

/* dv/sbfw_ctrl_tb.sv */
`timescale 1ns/1ns
module sbfw_ctrl_tb;
    import sbfw_pkg::*;
    logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0, wen = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, aslp = 0;
    logic [1:0] buf_mode = MODE_DISABLED;
    logic [4:0] pul = 0;
    logic [6:0] gn = 0;
    logic sample_wr, odr_tick, busy, sleep_mode;
    sbfw_status_s status;
    sbfw_gate_s gate;
    int mismatches = 0, total_checks = 0, cyc = 0, i;
    logic [31:0] seed = 32'hd051_34bc, r;
    logic [5:0] thr, n;
    sbfw_ctrl sbfw_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf_mode(buf_mode),
        .sample_wr(sample_wr), .sample_rd(pul[0]), .trigger_evt(pul[1]),
        .gate_err_set(pul[2]), .gate_cnt_inc(pul[3]),
        .autosleep_period(aslp), .odr_tick(odr_tick), .wake_evt(pul[4]),
        .status(status), .gate(gate), .sleep_mode(sleep_mode));
    sbfw_sample_src sbfw_sample_src_i (.core_clk(core_clk), .go(go),
        .n(gn), .wr_en(wen), .sample_wr(sample_wr), .odr_tick(odr_tick),
        .busy(busy));
    // ==========================================================
    // clock and watchdog
    initial begin
        forever #50 core_clk = !core_clk;
    end
    // the whole sequence needs well under ten thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge core_clk) #1;
        pul = m;
        @(posedge core_clk) #1;
        pul = 5'h00;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic gen(input logic [6:0] k, input logic w);
        @(posedge core_clk) #1;
        {go, gn, wen} = {1'b1, k, w};
        @(posedge core_clk) #1;
        go = 1'b0;
        for (int t = 0; t < 300 && busy === 1'b1; t++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        rd(CTRL_ADDR, CTRL_RESET);
        chk({2'b00, gate}, 8'h00);
        wr(CTRL_ADDR, 8'hc5);
        rd(CTRL_ADDR, 8'h45);
        wr(8'h28, 8'hff);
        rd(8'h28, 8'h00);
        rd(CTRL_ADDR, 8'h45);
        buf_mode = MODE_STREAM;
        // random threshold and fill, first pass with threshold zero
        for (i = 0; i < 8; i++) begin
            r = rnd();
            thr = (i == 0) ? 6'h00 : {1'b0, r[4:0]};
            n = {1'b0, r[12:8]};
            wr(CTRL_ADDR, {2'b00, thr});
            gen({1'b0, n}, 1'b1);
            chk(status, {1'b0, thr != 0 && n >= thr, n});
            if (n != 0) begin
                pulse(5'h01);
                n = n - 6'h01;
                chk(status, {1'b0, thr != 0 && n >= thr, n});
            end
            pulse(5'h0c);
            chk({2'b00, gate}, 8'h21);
            wr(CTRL_ADDR, {2'b10, thr});
            chk(status, 8'h00);
            chk({2'b00, gate}, 8'h00);
        end
        gen(7'd34, 1'b1);
        chk(status, {1'b1, thr != 6'h00, BUF_DEPTH});
        buf_mode = MODE_DISABLED;
        repeat (3) @(posedge core_clk);
        #1;
        chk(status, 8'h00);
        // triggered: four kept before trigger, then fill and stop
        buf_mode = MODE_TRIGGERED;
        wr(CTRL_ADDR, 8'h04);
        gen(7'd10, 1'b1);
        chk(status, 8'h44);
        pulse(5'h02);
        gen(7'd40, 1'b1);
        chk(status, {2'b11, BUF_DEPTH});
        gen(7'd2, 1'b1);
        chk(status, {2'b11, BUF_DEPTH});
        // auto-sleep after three idle ticks
        buf_mode = MODE_STREAM;
        aslp = 8'h03;
        wr(CTRL_ADDR, 8'h81);
        pulse(5'h10);
        gen(7'd1, 1'b0);
        gen(7'd1, 1'b1);
        gen(7'd1, 1'b0);
        chk({7'h00, sleep_mode}, 8'h01);
        wr(CTRL_ADDR, 8'h81);
        wr(CTRL_ADDR, 8'h41);
        pulse(5'h10);
        gen(7'd1, 1'b0);
        gen(7'd1, 1'b1);
        gen(7'd2, 1'b0);
        chk({7'h00, sleep_mode}, 8'h00);
        gen(7'd1, 1'b0);
        chk({7'h00, sleep_mode}, 8'h01);
        pulse(5'h10);
        gen(7'd2, 1'b0);
        wr(CTRL_ADDR, 8'hc1);
        gen(7'd2, 1'b0);
        chk({7'h00, sleep_mode}, 8'h00);
        gen(7'd1, 1'b0);
        chk({7'h00, sleep_mode}, 8'h01);
        // stop mode keeps the first 32, flags the refused sample
        buf_mode = MODE_STOP;
        wr(CTRL_ADDR, 8'h80);
        gen(7'd33, 1'b1);
        chk(status, {2'b10, BUF_DEPTH});
        // triggered mode ignores keep-awake, so the timer runs out
        buf_mode = MODE_TRIGGERED;
        wr(CTRL_ADDR, 8'hc2);
        pulse(5'h10);
        gen(7'd2, 1'b1);
        gen(7'd1, 1'b0);
        chk({7'h00, sleep_mode}, 8'h01);
        stop_test();
    end
endmodule
